/* File: hdl/terminal_decoder_defines.svh */
// Offsets, field positions, reset values and function codes of the input terminal decoder.
// Assumes a 32-bit Wishbone register bus with byte addresses.
`ifndef TERMINAL_DECODER_DEFINES_SVH
`define TERMINAL_DECODER_DEFINES_SVH

`define FUNC_LO_OFS 8'h00
`define FUNC_HI_OFS 8'h04
`define CTRL_OFS 8'h08
`define STATUS_OFS 8'h0C

`define CTRL_POL_BIT 0
`define CTRL_CMD_LSB 2
`define CTRL_STOP_LSB 4
`define CTRL_COMM_LSB 8
`define CTRL_MAIN_LSB 16
`define STATUS_CLASH_BIT 8

`define POL_RESET 1'h1
`define CMD_RESET 2'h0
`define STOP_RESET 2'h0
`define COMM_RESET 2'h0
`define MAIN_RESET 4'h0

`define FN_NONE 7'h00
`define FN_PID_PAUSE 7'h1D
`define FN_PID_CLEAR 7'h1E
`define FN_PID_HOLD 7'h1F
`define FN_SEL1 7'h22
`define FN_SEL2 7'h23
`define FN_SEL3 7'h24
`define FN_SEL4 7'h25
`define FN_CMD_KEYPAD 7'h26
`define FN_CMD_TERMINAL 7'h27
`define FN_CMD_COMM 7'h28
`define FN_REV_INHIBIT 7'h2A
`define FN_EXT_STOP 7'h2C
`define FN_MAX 7'h48
`define MAIN_MAX 4'h8

`endif

/* File: hdl/terminal_decoder_pkg.sv */
// Types shared by the input terminal decoder files.
// Assumes the defines header is compiled alongside.
package terminal_decoder_pkg;

    typedef logic [7:0][6:0] term_codes_t;

    typedef enum logic [1:0] {
        CMD_KEYPAD = 2'h0,
        CMD_TERMINAL = 2'h1,
        CMD_COMM = 2'h2
    } cmd_channel_t;

    typedef enum logic [3:0] {
        REF_PARAM = 4'h0,
        REF_ANALOG_ONE = 4'h1,
        REF_ANALOG_TWO = 4'h2,
        REF_PULSE = 4'h3,
        REF_PLC = 4'h4,
        REF_MULTI_SPEED = 4'h5,
        REF_PID = 4'h6,
        REF_MODBUS = 4'h7,
        REF_FIELDBUS = 4'h8
    } ref_channel_t;

    typedef struct packed {
        logic pause;
        logic clear;
        logic int_hold;
    } pid_ctrl_t;

    typedef struct packed {
        logic coast_stop;
        logic zero_freq;
        logic ext_stop;
        logic [1:0] stop_mode;
    } run_ctrl_t;

endpackage : terminal_decoder_pkg

/* File: hdl/terminal_sync.sv */
// Two-stage synchroniser bank for the digital input terminals.
// Assumes the terminal pins are asynchronous to clock_i.
`timescale 1ns/10ps
`default_nettype none

module terminal_sync
(
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic [7:0] pin_i,
    output logic [7:0] level_o
);

    logic [7:0] meta;

    genvar g;
    generate
        for (g = 0; g < 8; g++)
        begin : gen_sync
            // Only the second stage reads the first one.
            always_ff @(posedge clock_i)
            begin
                // Reset to the high idle level of low-active terminals, so no false activity follows reset.
                if (rst_i)
                begin
                    meta[g] <= 1'h1;
                    level_o[g] <= 1'h1;
                end
                else
                begin
                    meta[g] <= pin_i[g];
                    level_o[g] <= meta[g];
                end
            end
        end
    endgenerate

endmodule : terminal_sync

`default_nettype wire

/* File: hdl/terminal_decoder.sv */
// Decoder of the multi-function input terminals for PID, reference, command channel and stop functions.
// Assumes a classic Wishbone master and run status inputs from logic on the same clock.
//
// The Wishbone interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "terminal_decoder_defines.svh"

module terminal_decoder
    import terminal_decoder_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [7:0] term_pin_i,
    input wire logic rev_req_i,
    input wire logic running_i,
    input wire logic running_rev_i,
    output pid_ctrl_t pid_o,
    output ref_channel_t main_ref_o,
    output cmd_channel_t cmd_channel_o,
    output logic [1:0] comm_method_o,
    output run_ctrl_t run_o
);

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Decoding helpers.

    // Reports whether any active terminal carries the given function code.
    function automatic logic fn_active(input term_codes_t codes, input logic [7:0] act, input logic [6:0] code);
        logic hit;
        hit = 1'h0;
        for (int k = 0; k < 8; k++)
        begin
            if (codes[k] == code && act[k])
            begin
                hit = 1'h1;
            end
        end
        return hit;
    endfunction : fn_active

    // Reports whether terminal idx shares its nonzero code with another terminal.
    function automatic logic code_clash(input term_codes_t codes, input int idx);
        logic hit;
        hit = 1'h0;
        for (int k = 0; k < 8; k++)
        begin
            if (k != idx && codes[k] == codes[idx] && codes[idx] != `FN_NONE)
            begin
                hit = 1'h1;
            end
        end
        return hit;
    endfunction : code_clash

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Registers and state.

    term_codes_t codes;
    logic polarity;
    cmd_channel_t cmd_cfg;
    logic [1:0] stop_mode;
    logic [1:0] comm_method;
    logic [3:0] main_param;
    logic clash_flag;
    logic use_terminal;
    logic [3:0] sel_prev;
    logic rev_req_q;
    logic rev_hold;
    logic [7:0] active;

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Terminal inputs.

    wire [7:0] level;

    terminal_sync u_sync
    (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .pin_i(term_pin_i),
        .level_o(level)
    );

    wire [7:0] next_active = polarity ? ~level : level;

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            active <= 8'h00;
        end
        else
        begin
            active <= next_active;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Wishbone slave.

    wire req = wb_cyc_i & wb_stb_i;
    wire wr = req & wb_we_i & wb_ack_o;
    wire hit_lo = wb_adr_i == `FUNC_LO_OFS;
    wire hit_hi = wb_adr_i == `FUNC_HI_OFS;
    wire hit_ctrl = wb_adr_i == `CTRL_OFS;
    wire hit_status = wb_adr_i == `STATUS_OFS;
    wire [7:0] byte_wr = {{4{wr & hit_hi}} & wb_sel_i, {4{wr & hit_lo}} & wb_sel_i};
    wire ctrl_wr = wr & hit_ctrl;
    wire status_wr = wr & hit_status;

    term_codes_t cand;
    wire [7:0] refuse;

    genvar g;
    generate
        for (g = 0; g < 8; g++)
        begin : gen_code
            assign cand[g] = byte_wr[g] ? wb_dat_i[(g % 4) * 8 +: 7] : codes[g];
            assign refuse[g] = byte_wr[g] & (code_clash(cand, g) | (cand[g] > `FN_MAX));
            always_ff @(posedge clock_i)
            begin
                if (rst_i)
                begin
                    codes[g] <= `FN_NONE;
                end
                else if (byte_wr[g] & ~refuse[g])
                begin
                    codes[g] <= cand[g];
                end
            end
        end
    endgenerate

    wire [31:0] func_lo_rd = {1'h0, codes[3], 1'h0, codes[2], 1'h0, codes[1], 1'h0, codes[0]};
    wire [31:0] func_hi_rd = {1'h0, codes[7], 1'h0, codes[6], 1'h0, codes[5], 1'h0, codes[4]};
    wire [31:0] ctrl_rd = {12'h000, main_param, 6'h00, comm_method, 2'h0, stop_mode, cmd_cfg, 1'h0, polarity};
    // Status fields from bit 0: active terminals, clash flag, run flags, PID, main reference, channel.
    wire [2:0] run_flags = {run_o.coast_stop, run_o.zero_freq, run_o.ext_stop};
    wire [31:0] status_rd = {8'h00, cmd_channel_o, main_ref_o, pid_o, run_flags, 3'h0, clash_flag, active};
    wire [31:0] next_rd = hit_lo ? func_lo_rd :
                          hit_hi ? func_hi_rd :
                          hit_ctrl ? ctrl_rd :
                          hit_status ? status_rd : 32'h00000000;

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'h0;
            wb_dat_o <= 32'h00000000;
        end
        else
        begin
            wb_ack_o <= req & ~wb_ack_o;
            wb_dat_o <= next_rd;
        end
    end

    // Control register; each byte lane updates on its own.
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            polarity <= `POL_RESET;
            cmd_cfg <= cmd_channel_t'(`CMD_RESET);
            stop_mode <= `STOP_RESET;
            comm_method <= `COMM_RESET;
            main_param <= `MAIN_RESET;
        end
        else
        begin
            if (ctrl_wr & wb_sel_i[0])
            begin
                polarity <= wb_dat_i[`CTRL_POL_BIT];
                cmd_cfg <= cmd_channel_t'(wb_dat_i[`CTRL_CMD_LSB +: 2]);
                stop_mode <= wb_dat_i[`CTRL_STOP_LSB +: 2];
            end
            if (ctrl_wr & wb_sel_i[1])
            begin
                comm_method <= wb_dat_i[`CTRL_COMM_LSB +: 2];
            end
            if (ctrl_wr & wb_sel_i[2])
            begin
                main_param <= wb_dat_i[`CTRL_MAIN_LSB +: 4];
            end
        end
    end

    // Clash flag: a new clash wins over a write-one clear.
    wire next_clash = (|refuse) | (clash_flag & ~(status_wr & wb_sel_i[1] & wb_dat_i[`STATUS_CLASH_BIT]));

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            clash_flag <= 1'h0;
        end
        else
        begin
            clash_flag <= next_clash;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Function decoding.

    wire pause_on = fn_active(codes, active, `FN_PID_PAUSE);
    wire clear_on = fn_active(codes, active, `FN_PID_CLEAR);
    wire hold_on = fn_active(codes, active, `FN_PID_HOLD);
    wire keypad_on = fn_active(codes, active, `FN_CMD_KEYPAD);
    wire terminal_on = fn_active(codes, active, `FN_CMD_TERMINAL);
    wire comm_on = fn_active(codes, active, `FN_CMD_COMM);
    wire inhibit_on = fn_active(codes, active, `FN_REV_INHIBIT);
    wire ext_stop_on = fn_active(codes, active, `FN_EXT_STOP);

    wire [3:0] sel_code = {fn_active(codes, active, `FN_SEL4), fn_active(codes, active, `FN_SEL3),
                           fn_active(codes, active, `FN_SEL2), fn_active(codes, active, `FN_SEL1)};

    wire param_wr = ctrl_wr & wb_sel_i[2];
    wire sel_changed = sel_code != sel_prev;
    wire next_use_terminal = param_wr ? 1'h0 : (sel_changed ? 1'h1 : use_terminal);

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            use_terminal <= 1'h0;
            sel_prev <= 4'h0;
        end
        else
        begin
            use_terminal <= next_use_terminal;
            sel_prev <= sel_code;
        end
    end

    // Code zero or out of range falls back to the parameter.
    wire sel_valid = sel_code != 4'h0 && sel_code <= `MAIN_MAX;
    wire param_valid = main_param <= `MAIN_MAX;
    wire [3:0] param_ref = param_valid ? main_param : 4'h0;
    wire [3:0] next_main = (next_use_terminal && sel_valid) ? sel_code : param_ref;

    wire [1:0] cfg_code = (cmd_cfg == CMD_COMM || cmd_cfg == CMD_TERMINAL) ? cmd_cfg : 2'h0;
    wire [1:0] next_cmd = keypad_on ? 2'h0 :
                          terminal_on ? 2'h1 :
                          comm_on ? 2'h2 : cfg_code;

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Reverse inhibit and external stop.

    wire rev_rise = rev_req_i & ~rev_req_q;

    wire next_rev_hold = rev_req_i & (rev_hold | (rev_rise & inhibit_on));

    wire next_coast = inhibit_on & running_rev_i & ~next_rev_hold;

    wire next_ext_stop = ext_stop_on & running_i;

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            rev_req_q <= 1'h0;
            rev_hold <= 1'h0;
        end
        else
        begin
            rev_req_q <= rev_req_i;
            rev_hold <= next_rev_hold;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Registered outputs.

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            pid_o <= '0;
            main_ref_o <= REF_PARAM;
            cmd_channel_o <= CMD_KEYPAD;
            comm_method_o <= `COMM_RESET;
            run_o <= '0;
        end
        else
        begin
            pid_o.pause <= pause_on;
            pid_o.clear <= clear_on;
            pid_o.int_hold <= hold_on;
            main_ref_o <= ref_channel_t'(next_main);
            cmd_channel_o <= cmd_channel_t'(next_cmd);
            comm_method_o <= comm_method;
            run_o.coast_stop <= next_coast;
            run_o.zero_freq <= next_rev_hold;
            run_o.ext_stop <= next_ext_stop;
            run_o.stop_mode <= stop_mode;
        end
    end

endmodule : terminal_decoder

`default_nettype wire

/* File: dv/terminal_decoder_asserts.sv */
// Concurrent checks on the ports of the input terminal decoder.
// Assumes it is bound into terminal_decoder, one clock, synchronous reset.
`timescale 1ns/10ps
`default_nettype none
module terminal_decoder_asserts
    import terminal_decoder_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic rev_req_i,
    input wire logic running_i,
    input wire logic running_rev_i,
    input wire ref_channel_t main_ref_o,
    input wire cmd_channel_t cmd_channel_o,
    input wire run_ctrl_t run_o
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held over one cycle");
    chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request left unanswered");
    chk_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i[7:4] != 4'h0 |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    chk_main_range: assert property (main_ref_o <= REF_FIELDBUS)
        else $error("main reference out of range");
    chk_cmd_legal: assert property (cmd_channel_o != 2'h3)
        else $error("illegal command channel");
    chk_coast_cause: assert property (run_o.coast_stop |-> $past(running_rev_i))
        else $error("coast without reverse running");
    chk_zero_cause: assert property (run_o.zero_freq |-> $past(rev_req_i))
        else $error("zero frequency without reverse request");
    chk_fwd_free: assert property (!running_rev_i && !rev_req_i |=> !run_o.coast_stop && !run_o.zero_freq)
        else $error("forward running disturbed");
    chk_stop_running: assert property (run_o.ext_stop |-> $past(running_i))
        else $error("external stop while not running");
    ////////////////////////////////////////////////////////////
    cov_coast: cover property (run_o.coast_stop);
    cov_zero: cover property (run_o.zero_freq);
    cov_stop: cover property (run_o.ext_stop);
    cov_comm: cover property (cmd_channel_o == CMD_COMM);
endmodule : terminal_decoder_asserts
bind terminal_decoder terminal_decoder_asserts u_chk
(
    .clock_i(clock_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rev_req_i(rev_req_i),
    .running_i(running_i), .running_rev_i(running_rev_i), .main_ref_o(main_ref_o),
    .cmd_channel_o(cmd_channel_o), .run_o(run_o)
);
`default_nettype wire

/* File: dv/terminal_switch_model.sv */
// Switch bank that drives the eight input terminals.
// Assumes the bench gives the wanted active terminals and the polarity.
`timescale 1ns/10ps
`default_nettype none
module terminal_switch_model
(
    input wire logic clock_i,
    input wire logic [7:0] active_i,
    input wire logic pol_i,
    output logic [7:0] pin_o
);
    always_ff @(posedge clock_i)
    begin
        pin_o <= pol_i ? ~active_i : active_i;
    end
endmodule : terminal_switch_model
`default_nettype wire

/* File: dv/tb_top.sv */
// Self-checking bench of the terminal decoder against a behavioural model.
// Assumes the design, the switch model and the checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import terminal_decoder_pkg::*;
;
    localparam int SETTLE = 6;
    logic clock_i = 1'h0, rst_i = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0, pol = 1'h1;
    logic rev_req = 1'h0, run = 1'h0, run_rev = 1'h0, ack;
    logic [7:0] adr = 8'h00, act = 8'h00, pins;
    logic [3:0] sel = 4'hF;
    logic [31:0] wdat = 32'h0, dat, rd, lfsr = 32'h10FD;
    pid_ctrl_t pid;
    ref_channel_t mref;
    cmd_channel_t cmd;
    logic [1:0] comm;
    run_ctrl_t ro;
    int miscompares = 0, checks = 0, cmdcfg = 0, stopm = 0, method = 0, param = 0, src = 0;
    int code [8] = '{default: 0};
    always #4 clock_i = ~clock_i;
    terminal_switch_model u_sw (.clock_i(clock_i), .active_i(act), .pol_i(pol), .pin_o(pins));
    terminal_decoder u_dut
    (
        .clock_i(clock_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat), .wb_ack_o(ack), .term_pin_i(pins),
        .rev_req_i(rev_req), .running_i(run), .running_rev_i(run_rev), .pid_o(pid), .main_ref_o(mref),
        .cmd_channel_o(cmd), .comm_method_o(comm), .run_o(ro)
    );
    ////////////////////////////////////////////////////////////
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : next_rand
    function automatic logic on(input int f);
        logic hit;
        hit = 1'h0;
        for (int i = 0; i < 8; i++)
            if (code[i] == f && act[i]) hit = 1'h1;
        return hit;
    endfunction : on
    function automatic logic [13:0] expect_out();
        logic [3:0] s;
        int r;
        int c;
        s = {on(37), on(36), on(35), on(34)};
        r = (param > 8) ? 0 : param;
        if (src == 1 && s != 4'h0 && s <= 4'h8) r = int'(s);
        c = on(38) ? 0 : on(39) ? 1 : on(40) ? 2 : cmdcfg % 3;
        return {on(29), on(30), on(31), 4'(r), 2'(c), 2'(method), on(44) & run, 2'(stopm)};
    endfunction : expect_out
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        wdat <= d;
        do
        begin
            @(posedge clock_i);
        end
        while (ack !== 1'h1);
        rd = dat;
        cyc <= 1'h0;
        stb <= 1'h0;
        @(posedge clock_i);
    endtask : wb
    task automatic ctrl(input logic p, input int c, input int s, input int m, input int r);
        wb(1'h1, 8'h08, {12'h0, 4'(r), 6'h0, 2'(m), 2'h0, 2'(s), 2'(c), 1'h0, p});
        pol <= p;
        cmdcfg = c;
        stopm = s;
        method = m;
        param = r;
        src = 0;
    endtask : ctrl
    task automatic setcodes(input logic [31:0] lo, input logic [31:0] hi);
        wb(1'h1, 8'h00, lo);
        wb(1'h1, 8'h04, hi);
        for (int i = 0; i < 4; i++)
        begin
            code[i] = int'(lo[8 * i +: 7]);
            code[i + 4] = int'(hi[8 * i +: 7]);
        end
    endtask : setcodes
    task automatic setact(input logic [7:0] a);
        if (a[7:4] != act[7:4]) src = 1;
        act <= a;
        @(posedge clock_i);
    endtask : setact
    task automatic chkall();
        repeat (SETTLE) @(posedge clock_i);
        chk(32'({pid, mref, cmd, comm, ro.ext_stop, ro.stop_mode}), 32'(expect_out()));
    endtask : chkall
    task automatic summarize();
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : summarize
    ////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20000) @(posedge clock_i);
        miscompares++;
        summarize();
    end
    initial
    begin
        repeat (12) @(posedge clock_i);
        rst_i <= 1'h0;
        @(posedge clock_i);
        wb(1'h0, 8'h0C, 32'h0);
        chk(rd, 32'h0);
        wb(1'h1, 8'h10, 32'hFFFFFFFF);
        wb(1'h0, 8'h10, 32'h0);
        chk(rd, 32'h0);
        wb(1'h0, 8'h08, 32'h0);
        chk(rd, 32'h1);
        setcodes(32'h2A1E1F1D, 32'h25242322);
        wb(1'h1, 8'h04, 32'h2524231D);
        wb(1'h0, 8'h04, 32'h0);
        chk(rd, 32'h25242322);
        wb(1'h1, 8'h00, 32'h2A1E1F7F);
        wb(1'h0, 8'h00, 32'h0);
        chk(rd, 32'h2A1E1F1D);
        wb(1'h0, 8'h0C, 32'h0);
        chk(32'(rd[8]), 32'h1);
        wb(1'h1, 8'h0C, 32'h100);
        wb(1'h0, 8'h0C, 32'h0);
        chk(32'(rd[8]), 32'h0);
        for (int i = 0; i < 16; i++)
        begin
            lfsr = next_rand(lfsr);
            setact({i[3:0], 1'h0, lfsr[2:0]});
            chkall();
            if (i % 4 == 3)
            begin
                ctrl(1'h1, 0, 0, 0, int'(lfsr[11:8]));
                chkall();
            end
        end
        run <= 1'h1;
        run_rev <= 1'h1;
        setact(8'h08);
        chkall();
        chk(32'(ro.coast_stop), 32'h1);
        run <= 1'h0;
        run_rev <= 1'h0;
        rev_req <= 1'h1;
        chkall();
        chk(32'({ro.coast_stop, ro.zero_freq}), 32'h1);
        rev_req <= 1'h0;
        run <= 1'h1;
        chkall();
        chk(32'({ro.coast_stop, ro.zero_freq}), 32'h0);
        setcodes(32'h2C282726, 32'h25242322);
        for (int k = 0; k < 64; k++)
        begin
            lfsr = next_rand(lfsr);
            if (k % 16 == 0) ctrl(1'h1, k / 16, int'(lfsr[5:4]), int'(lfsr[9:8]), param);
            run <= lfsr[0];
            setact({act[7:4], k[3:0]});
            chkall();
        end
        sel <= 4'h4;
        wb(1'h1, 8'h08, 32'hFFFFFFFF);
        sel <= 4'hF;
        param = 15;
        src = 0;
        wb(1'h0, 8'h08, 32'h0);
        chk(rd, {12'h0, 4'hF, 6'h0, 2'(method), 2'h0, 2'(stopm), 2'(cmdcfg), 1'h0, 1'h1});
        chkall();
        ctrl(1'h0, 1, 0, 0, 3);
        src = 1;
        setact(8'h5A);
        chkall();
        wb(1'h0, 8'h0C, 32'h0);
        chk(32'(rd[7:0]), 32'h5A);
        summarize();
    end
endmodule : tb_top
`default_nettype wire
